// [rtl/cbz_pkg.sv]
package cbz_pkg;
   // Notes on behaviour
   // - control bit 2 picks chained or legacy protocol
   // - legacy reads only while read enable set
   // - chained protocol ignores the read enable bit
   // - control bit 0 resets converter and registers
   // - read-only mirror of the control word
   // - chain length bits 6..2, value n means n+1
   // - bank select 0, 2, 16 picks bank 0, 1, 2
   // - bank 0 reachable whatever bank is selected
   // - 24-bit frames, read answered in next frame
   // - chained input reaches output 24 clocks later
   // - 0xfe frame loads shifter, ones frame drains it

   // register addresses of bank 0
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CHAIN = 8'h01;
   localparam logic [7:0] ADDR_BANK = 8'h03;
   localparam logic [7:0] ADDR_INIT = 8'h04;
   localparam logic [7:0] ADDR_MIRROR = 8'h06;

   // control word bit positions
   localparam int BIT_SOFT_RST = 0;
   localparam int BIT_RD_EN = 1;
   localparam int BIT_LEGACY = 2;
   // chain length field position
   localparam int CHAIN_LSB = 2;
   localparam int CHAIN_MSB = 6;
   // init field top bit
   localparam int INIT_MSB = 3;

   // reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [4:0] CHAIN_RST = 5'h00;
   localparam logic [7:0] BANK_RST = 8'h02;
   localparam logic [3:0] INIT_RST = 4'h0;
   localparam logic [15:0] MIRROR_RST = 16'h0002;

   // bank select codes and the init code for normal operation
   localparam logic [7:0] BANK0_CODE = 8'h00;
   localparam logic [7:0] BANK1_CODE = 8'h02;
   localparam logic [7:0] BANK2_CODE = 8'h10;
   localparam logic [3:0] INIT_GOOD = 4'h3;

   // chained read commands
   localparam logic [7:0] CHAIN_RD_CMD = 8'hfe;
   localparam logic [7:0] DRAIN_CMD = 8'hff;

   // frame timing in serial clocks
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam logic [4:0] DATA_SLOT = 5'h07;

   // decoded bank
   typedef enum logic [1:0] {
      CBZ_BANK0 = 2'h0,
      CBZ_BANK1 = 2'h1,
      CBZ_BANK2 = 2'h3,
      CBZ_BANK_NONE = 2'h2
   } cbz_bank_t;
endpackage

// [rtl/cbz_regs.sv]
module cbz_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic legacy_mode,
   output logic [4:0] chain_length,
   output logic [7:0] bank_sel,
   output cbz_pkg::cbz_bank_t bank_dec,
   output logic init_ok,
   output logic conv_rst
);

   // ---- system clock domain state ----
   logic [2:0] ctrl_r, ctrl_nxt; // legacy, read enable, soft reset
   logic [4:0] chain_r, chain_nxt; // chain length field
   logic [7:0] bank_r, bank_nxt; // bank select field
   logic [3:0] init_r, init_nxt; // init field
   logic [15:0] mirror_r, mirror_nxt; // control word copy
   logic [15:0] rd_data_r, rd_data_nxt; // answer for next frame
   logic rd_rdy_r, rd_rdy_nxt; // answer waiting to go out
   logic conv_rst_r, conv_rst_nxt; // converter reset pulse
   logic lrst_r, lrst_nxt; // link side reset
   cbz_pkg::cbz_bank_t bank_dec_r, bank_dec_nxt;
   logic init_ok_r, init_ok_nxt;
   // chip select synchroniser and edge stage
   logic cs_s1_r, cs_s2_r, cs_s3_r;

   // ---- link clock domain state ----
   logic [4:0] bit_cnt_r, bit_cnt_nxt; // position in 24-bit word
   logic [23:0] rx_r, rx_nxt; // received word
   logic [23:0] dly_r, dly_nxt; // delay line and answer shifter
   logic [1:0] mode_s1_r, mode_s2_r; // legacy, read enable
   logic rdy_s1_r, rdy_s2_r; // answer ready, synchronised

   // ---- frame decode in the system domain ----
   logic frame_end; // chip select just released
   logic legacy; // legacy protocol selected
   logic rd_en; // legacy reads allowed
   logic [7:0] op; // first byte of last word
   logic is_rd; // last word asks for a read
   logic is_wr; // last word writes a register
   logic [7:0] rd_addr; // address to read
   logic [15:0] wdata; // data to write
   logic wr_ctrl; // write to the control word

   // rx_r is stable here: the link clock stops while chip select is high
   assign frame_end = cs_s2_r & ~cs_s3_r;
   assign legacy = ctrl_r[cbz_pkg::BIT_LEGACY];
   assign rd_en = ctrl_r[cbz_pkg::BIT_RD_EN];
   assign op = rx_r[23:16];
   assign wdata = rx_r[15:0];

   // read or write decision for the finished frame
   always_comb begin
      if (legacy) begin
         // a control write stays possible so reads can be switched off
         is_rd = rd_en && (op != cbz_pkg::ADDR_CTRL);
         is_wr = !is_rd;
         rd_addr = op;
      end else begin
         // read enable is not looked at in chained mode
         is_rd = (op == cbz_pkg::CHAIN_RD_CMD);
         is_wr = !is_rd && (op != cbz_pkg::DRAIN_CMD);
         rd_addr = rx_r[7:0];
      end
   end

   assign wr_ctrl = frame_end && is_wr && (op == cbz_pkg::ADDR_CTRL);

   // register read mux; bank 0 decodes without looking at bank select
   function automatic logic [15:0] rd_val(input logic [7:0] a);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         cbz_pkg::ADDR_CHAIN: v = 16'(chain_r) << cbz_pkg::CHAIN_LSB;
         cbz_pkg::ADDR_BANK: v = 16'(bank_r);
         cbz_pkg::ADDR_INIT: v = 16'(init_r);
         cbz_pkg::ADDR_MIRROR: v = mirror_r;
         // control word is write-only; banks 1 and 2 live elsewhere
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // next state of the register bank
   always_comb begin
      ctrl_nxt = ctrl_r;
      chain_nxt = chain_r;
      bank_nxt = bank_r;
      init_nxt = init_r;
      mirror_nxt = mirror_r;
      rd_data_nxt = rd_data_r;
      rd_rdy_nxt = rd_rdy_r;
      conv_rst_nxt = 1'b0;
      lrst_nxt = 1'b0;
      if (frame_end) begin
         // ready stands through the following frame only
         rd_rdy_nxt = is_rd;
         if (is_rd) begin
            rd_data_nxt = rd_val(rd_addr);
         end else if (is_wr) begin
            unique case (op)
               cbz_pkg::ADDR_CTRL: begin
                  if (wdata[cbz_pkg::BIT_SOFT_RST]) begin
                     // whole bank back to defaults, converter told too
                     ctrl_nxt = cbz_pkg::CTRL_RST;
                     chain_nxt = cbz_pkg::CHAIN_RST;
                     bank_nxt = cbz_pkg::BANK_RST;
                     init_nxt = cbz_pkg::INIT_RST;
                     mirror_nxt = cbz_pkg::MIRROR_RST;
                     rd_rdy_nxt = 1'b0;
                     conv_rst_nxt = 1'b1;
                     lrst_nxt = 1'b1;
                  end else begin
                     ctrl_nxt = wdata[cbz_pkg::BIT_LEGACY:cbz_pkg::BIT_SOFT_RST];
                     mirror_nxt = wdata;
                  end
               end
               cbz_pkg::ADDR_CHAIN: begin
                  chain_nxt = wdata[cbz_pkg::CHAIN_MSB:cbz_pkg::CHAIN_LSB];
               end
               cbz_pkg::ADDR_BANK: begin
                  bank_nxt = wdata[7:0];
               end
               cbz_pkg::ADDR_INIT: begin
                  init_nxt = wdata[cbz_pkg::INIT_MSB:0];
               end
               // mirror is read-only, other addresses are not here
               default: begin
                  mirror_nxt = mirror_r;
               end
            endcase
         end
      end
      // bank decode; unlisted codes select nothing
      unique case (bank_r)
         cbz_pkg::BANK0_CODE: bank_dec_nxt = cbz_pkg::CBZ_BANK0;
         cbz_pkg::BANK1_CODE: bank_dec_nxt = cbz_pkg::CBZ_BANK1;
         cbz_pkg::BANK2_CODE: bank_dec_nxt = cbz_pkg::CBZ_BANK2;
         default: bank_dec_nxt = cbz_pkg::CBZ_BANK_NONE;
      endcase
      init_ok_nxt = (init_r == cbz_pkg::INIT_GOOD);
      if (srst) begin
         lrst_nxt = 1'b1;
      end
   end

   // system domain registers
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= cbz_pkg::CTRL_RST;
         chain_r <= cbz_pkg::CHAIN_RST;
         bank_r <= cbz_pkg::BANK_RST;
         init_r <= cbz_pkg::INIT_RST;
         mirror_r <= cbz_pkg::MIRROR_RST;
         rd_data_r <= 16'h0000;
         rd_rdy_r <= 1'b0;
         conv_rst_r <= 1'b0;
         lrst_r <= 1'b1;
         bank_dec_r <= cbz_pkg::CBZ_BANK1;
         init_ok_r <= 1'b0;
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
      end else begin
         ctrl_r <= ctrl_nxt;
         chain_r <= chain_nxt;
         bank_r <= bank_nxt;
         init_r <= init_nxt;
         mirror_r <= mirror_nxt;
         rd_data_r <= rd_data_nxt;
         rd_rdy_r <= rd_rdy_nxt;
         conv_rst_r <= conv_rst_nxt;
         lrst_r <= lrst_nxt;
         bank_dec_r <= bank_dec_nxt;
         init_ok_r <= init_ok_nxt;
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
      end
   end

   assign legacy_mode = ctrl_r[cbz_pkg::BIT_LEGACY];
   assign chain_length = chain_r;
   assign bank_sel = bank_r;
   assign bank_dec = bank_dec_r;
   assign init_ok = init_ok_r;
   assign conv_rst = conv_rst_r;

   // ---- link domain: shifting on the serial clock ----
   always_comb begin
      rx_nxt = {rx_r[22:0], sdi};
      // plain delay line: 24 stages from input to output
      dly_nxt = {dly_r[22:0], sdi};
      if (bit_cnt_r == cbz_pkg::LAST_BIT) begin
         bit_cnt_nxt = 5'h00;
      end else begin
         bit_cnt_nxt = bit_cnt_r + 5'h01;
      end
      if (bit_cnt_r == cbz_pkg::LAST_BIT) begin
         // word complete: a read command loads the address part now
         if (mode_s2_r[1]) begin
            if (mode_s2_r[0] && rx_nxt[23:16] != cbz_pkg::ADDR_CTRL) begin
               dly_nxt = {rx_nxt[23:16], 16'h0000};
            end
         end else if (rx_nxt[23:16] == cbz_pkg::CHAIN_RD_CMD) begin
            dly_nxt = {rx_nxt[7:0], 16'h0000};
         end
      end else if (bit_cnt_r == cbz_pkg::DATA_SLOT && rdy_s2_r) begin
         // data slot: the answer from the system side is stable by now
         dly_nxt = {rd_data_r, dly_r[6:0], sdi};
      end
   end

   // bit counter restarts at every frame start
   always_ff @(posedge sclk or posedge cs_n or posedge lrst_r) begin
      if (lrst_r || cs_n) begin
         bit_cnt_r <= 5'h00;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
      end
   end

   // link registers; they persist across frames to carry answers
   always_ff @(posedge sclk or posedge lrst_r) begin
      if (lrst_r) begin
         rx_r <= 24'h000000;
         dly_r <= 24'h000000;
         mode_s1_r <= 2'h0;
         mode_s2_r <= 2'h0;
         rdy_s1_r <= 1'b0;
         rdy_s2_r <= 1'b0;
      end else begin
         rx_r <= rx_nxt;
         dly_r <= dly_nxt;
         mode_s1_r <= {ctrl_r[cbz_pkg::BIT_LEGACY], ctrl_r[cbz_pkg::BIT_RD_EN]};
         mode_s2_r <= mode_s1_r;
         rdy_s1_r <= rd_rdy_r;
         rdy_s2_r <= rdy_s1_r;
      end
   end

   assign sdo = dly_r[23];

   // ---- checks ----
   a_soft_reset: assert property (@(posedge clk) disable iff (srst)
      (wr_ctrl && wdata[cbz_pkg::BIT_SOFT_RST]) |=> conv_rst ##1 !conv_rst)
      else $error("soft reset did not give one converter reset pulse");

   a_soft_defaults: assert property (@(posedge clk) disable iff (srst)
      (wr_ctrl && wdata[cbz_pkg::BIT_SOFT_RST]) |=>
      (bank_sel == cbz_pkg::BANK_RST && chain_length == cbz_pkg::CHAIN_RST
       && mirror_r == cbz_pkg::MIRROR_RST && !legacy_mode))
      else $error("soft reset left a field off its default");

   a_mirror_copy: assert property (@(posedge clk) disable iff (srst)
      (wr_ctrl && !wdata[cbz_pkg::BIT_SOFT_RST]) |=>
      (mirror_r == $past(wdata) && legacy_mode == $past(wdata[cbz_pkg::BIT_LEGACY])))
      else $error("mirror does not follow the control word");

   a_chain_len: assert property (@(posedge clk) disable iff (srst)
      (frame_end && is_wr && op == cbz_pkg::ADDR_CHAIN) |=>
      chain_length == $past(wdata[cbz_pkg::CHAIN_MSB:cbz_pkg::CHAIN_LSB]))
      else $error("chain length not taken from bits 6 to 2");

   a_bank_decode: assert property (@(posedge clk) disable iff (srst)
      (bank_sel == cbz_pkg::BANK2_CODE) [*2] |-> bank_dec == cbz_pkg::CBZ_BANK2)
      else $error("bank code 16 not decoded as bank 2");

   a_chain_ignore: assert property (@(posedge clk) disable iff (srst)
      (frame_end && !legacy && op != cbz_pkg::CHAIN_RD_CMD
       && op != cbz_pkg::DRAIN_CMD) |-> is_wr && !is_rd)
      else $error("read enable changed a chained write");

   a_legacy_read: assert property (@(posedge clk) disable iff (srst)
      (frame_end && legacy && op != cbz_pkg::ADDR_CTRL) |=>
      (rd_rdy_r == $past(rd_en)))
      else $error("legacy read not gated by read enable");

   a_delay_line: assert property (@(posedge sclk) disable iff (lrst_r || cs_n)
      (bit_cnt_r != cbz_pkg::LAST_BIT && bit_cnt_r != cbz_pkg::DATA_SLOT) |=>
      dly_r == {$past(dly_r[22:0]), $past(sdi)})
      else $error("delay line did not shift by one stage");

   a_chain_load: assert property (@(posedge sclk) disable iff (lrst_r || cs_n)
      (bit_cnt_r == cbz_pkg::LAST_BIT && !mode_s2_r[1]
       && rx_nxt[23:16] == cbz_pkg::CHAIN_RD_CMD) |=>
      dly_r == {$past(rx_r[6:0]), $past(sdi), 16'h0000})
      else $error("chained read did not load the address");

   // every accepted read must raise ready for the frame that follows
   a_read_ready: assert property (@(posedge clk) disable iff (srst)
      (frame_end && is_rd) |=> rd_rdy_r)
      else $error("read answer not flagged for the next frame");

   // the control word is write-only; only its mirror may carry it out
   a_ctrl_unread: assert property (@(posedge clk) disable iff (srst)
      (frame_end && is_rd && rd_addr == cbz_pkg::ADDR_CTRL) |=> rd_data_r == 16'h0000)
      else $error("write-only control word was read back");

   // a code outside the three listed ones must select no bank at all
   a_bank_none: assert property (@(posedge clk) disable iff (srst)
      (bank_sel != cbz_pkg::BANK0_CODE && bank_sel != cbz_pkg::BANK1_CODE
       && bank_sel != cbz_pkg::BANK2_CODE) [*2] |-> bank_dec == cbz_pkg::CBZ_BANK_NONE)
      else $error("unlisted bank code decoded as a bank");

endmodule

// [tb/cbz_host.sv]
// host controller on the configuration link; sclk runs only inside frames
module cbz_host (
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle: clock parked low, chip select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // one frame of n bits msb first, 64 ns clock; sdo taken at each rise
   task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] got);
      got = '0;
      #17 cs_n = 1'b0; // odd offset keeps the link unrelated in phase to clk
      for (int i = n - 1; i >= 0; i--) begin
         sdi = w[i];
         #32 sclk = 1'b1;
         got = {got[46:0], sdo}; // value before the edge lands
         #32 sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      sdi = ~sdi; // released line shows no stale level
      #1200; // gap lets the word cross into the clk domain and the answer form
   endtask
endmodule

// [tb/config_bank_zero_registers_tb.sv]
module config_bank_zero_registers_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sclk, cs_n, sdi, sdo, legacy_mode, init_ok, conv_rst;
   logic [4:0] chain_length;
   logic [7:0] bank_sel;
   cbz_pkg::cbz_bank_t bank_dec;
   logic [47:0] got;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int pulses = 0; // conv_rst high cycles seen
   always #50 clk = ~clk;

   cbz_regs dut_u (
      .clk(clk),
      .srst(srst),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo(sdo),
      .legacy_mode(legacy_mode),
      .chain_length(chain_length),
      .bank_sel(bank_sel),
      .bank_dec(bank_dec),
      .init_ok(init_ok),
      .conv_rst(conv_rst)
   );
   cbz_host host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   // cycle ceiling cuts a hang short; the whole run needs about 1000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (conv_rst === 1'b1) pulses <= pulses + 1;
      if (cycles == 6000) begin
         n_errors = n_errors + 1;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // register write; reserved bits always sent as zero
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host_u.xfer({24'h0, a, d}, 24, got);
   endtask

   // read: command word then a filler frame that drains {addr, data}
   task automatic rd(input logic [23:0] cmd, input logic [7:0] a, input logic [15:0] exp);
      host_u.xfer({24'h0, cmd}, 24, got);
      host_u.xfer(48'hffffff, 24, got);
      check("read back", got[23:0], {a, exp});
   endtask

   // all outputs but sdo at their defaults
   task automatic chk_defaults();
      check("defaults", {legacy_mode, chain_length, bank_sel, bank_dec, init_ok, conv_rst},
         {1'b0, 5'h00, 8'h02, 2'h1, 1'b0, 1'b0});
   endtask

   // chain length top value and chained read back
   task automatic t_chain();
      wr(8'h01, 16'h000c);
      check("chain_length", chain_length, 5'h03);
      wr(8'h01, 16'h007c);
      check("chain_length", chain_length, 5'h1f);
      rd({16'hfe00, 8'h01}, 8'h01, 16'h007c);
   endtask

   // every bank code plus one invalid code; bank 0 stays reachable
   task automatic t_bank();
      logic [7:0] code [4] = '{8'h00, 8'h02, 8'h10, 8'h05};
      logic [1:0] dec [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      for (int i = 0; i < 4; i++) begin
         wr(8'h03, {8'h00, code[i]});
         check("bank_dec", {bank_sel, bank_dec}, {code[i], dec[i]});
      end
      wr(8'h03, 16'h0010);
      rd({16'hfe00, 8'h01}, 8'h01, 16'h007c);
      rd({16'hfe00, 8'h03}, 8'h03, 16'h0010);
   endtask

   // host programs the init code
   task automatic t_init();
      wr(8'h04, 16'h0003);
      check("init_ok", init_ok, 1'b1);
      wr(8'h04, 16'h0005);
      check("init_ok", init_ok, 1'b0);
      wr(8'h04, 16'h0003);
   endtask

   // protocol select, read enable, mirror
   task automatic t_modes();
      wr(8'h00, 16'h0002);
      check("legacy_mode", legacy_mode, 1'b0);
      wr(8'h01, 16'h0008);
      check("chain_length", chain_length, 5'h02);
      rd({16'hfe00, 8'h06}, 8'h06, 16'h0002);
      wr(8'h00, 16'h0004);
      check("legacy_mode", legacy_mode, 1'b1);
      wr(8'h01, 16'h0010);
      check("chain_length", chain_length, 5'h04);
      wr(8'h00, 16'h0006);
      rd({8'h01, 16'h0000}, 8'h01, 16'h0010);
      check("chain_length", chain_length, 5'h04);
      rd({8'h06, 16'h0000}, 8'h06, 16'h0006);
      wr(8'h00, 16'h0000);
      check("legacy_mode", legacy_mode, 1'b0);
   endtask

   // second word of a long frame comes out as the first word delayed 24 clocks
   task automatic t_delay();
      host_u.xfer({24'h5a3c96, 24'hffffff}, 48, got);
      check("delayed sdo", got[23:0], 24'h5a3c96);
   endtask

   // soft reset clears the bank and pulses the converter reset once
   task automatic t_soft();
      int p0;
      wr(8'h01, 16'h000c);
      wr(8'h03, 16'h0010);
      p0 = pulses;
      wr(8'h00, 16'h0001);
      check("conv_rst pulses", pulses - p0, 1);
      chk_defaults();
      rd({16'hfe00, 8'h06}, 8'h06, 16'h0002);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #5 srst = 1'b0;
      repeat (5) @(posedge clk);
      chk_defaults();
      t_chain();
      t_bank();
      t_init();
      t_modes();
      t_delay();
      t_soft();
      tally_and_finish();
   end
endmodule
